// file: hdl/asc_params.svh
// Purpose: offsets, field positions, reset values and counts of the serial port
// Assumes: byte-wide register port on a 16-bit address
// Notes: included by the top module, the assertion module and the testbench
`ifndef ASC_PARAMS_SVH
`define ASC_PARAMS_SVH

`define ASC_ADDR_PORT_DIR 16'hFF21
`define ASC_ADDR_MODE 16'hFF70
`define ASC_ADDR_BAUD 16'hFF71
`define ASC_ADDR_DATA 16'hFF72
`define ASC_ADDR_STATUS 16'hFF73

`define ASC_RST_PORT_DIR 8'hFF
`define ASC_RST_MODE 8'h01
`define ASC_RST_BAUD 8'h1F
`define ASC_RST_STATUS 8'h00
`define ASC_RST_BUFFER 8'hFF

`define ASC_MODE_POWER 7
`define ASC_MODE_TXE 6
`define ASC_MODE_RXE 5
`define ASC_MODE_PS_HI 4
`define ASC_MODE_PS_LO 3
`define ASC_MODE_CL 2
`define ASC_MODE_SL 1

`define ASC_STAT_PE 2
`define ASC_STAT_FE 1
`define ASC_STAT_OVE 0

`define ASC_BAUD_TPS_HI 7
`define ASC_BAUD_TPS_LO 6
`define ASC_BAUD_MASK 8'hDF
`define ASC_STAT_MASK 8'h07

`define ASC_PRE_DIV2 5'h01
`define ASC_PRE_DIV8 5'h07
`define ASC_PRE_DIV32 5'h1F

`define ASC_LEN_SHORT 4'h7
`define ASC_LEN_LONG 4'h8
`define ASC_FRAME_W 12

`endif

// file: hdl/asc_pkg.sv
// Purpose: types shared by the serial port
// Assumes: constants come from asc_params.svh
// Notes: enumerations only
package asc_pkg;
   typedef enum logic [1:0] {
      ASC_PAR_NONE,
      ASC_PAR_ZERO,
      ASC_PAR_ODD,
      ASC_PAR_EVEN
   } asc_parity_t;

   typedef enum logic [1:0] {
      ASC_BASE_TIMER,
      ASC_BASE_DIV2,
      ASC_BASE_DIV8,
      ASC_BASE_DIV32
   } asc_base_sel_t;

   typedef enum {
      ASC_RX_IDLE,
      ASC_RX_START,
      ASC_RX_DATA,
      ASC_RX_STOP
   } asc_rx_state_t;
endpackage

// file: hdl/asc_serial_port.sv
// Purpose: control, error status and baud generation of an asynchronous serial port
// Assumes: one clock; register port driven by logic on clk; rx pin is asynchronous
// Notes: the power bit acts as a synchronous clear, one clock after it falls
`timescale 1ns/1ns
`include "asc_params.svh"

module asc_serial_port #(
   parameter int ADDR_W = 16
) (
   input wire logic clk,
   input wire logic reset_n,
   input wire logic [ADDR_W-1:0] bus_addr,
   input wire logic bus_wr,
   input wire logic bus_rd,
   input wire logic [7:0] bus_wdata,
   output logic [7:0] bus_rdata,
   output logic bus_wait,
   input wire logic eight_bit_timer_output,
   input wire logic serial_rx_pin,
   output logic serial_tx_pin,
   output logic [7:0] port1_direction,
   output logic tx_complete,
   output logic rx_complete,
   output logic rx_error
);

   // frame image sent lsb first, all unused positions idle high
   function automatic logic [`ASC_FRAME_W-1:0] asc_frame(input logic [7:0] d,
         input asc_pkg::asc_parity_t ps, input logic long_chr);
      logic [`ASC_FRAME_W-1:0] v;
      logic [3:0] len;
      logic p;
      v = '1;
      len = long_chr ? `ASC_LEN_LONG : `ASC_LEN_SHORT;
      p = ^(d & (long_chr ? 8'hFF : 8'h7F));
      v[0] = 1'b0;
      for (int i = 0; i < 8; i++) begin
         if (i < int'(len)) begin
            v[i + 1] = d[i];
         end
      end
      unique case (ps)
         asc_pkg::ASC_PAR_NONE: v[len + 4'h1] = 1'b1;
         asc_pkg::ASC_PAR_ZERO: v[len + 4'h1] = 1'b0;
         asc_pkg::ASC_PAR_ODD: v[len + 4'h1] = ~p;
         asc_pkg::ASC_PAR_EVEN: v[len + 4'h1] = p;
      endcase
      return v;
   endfunction

   // number of line bits the transmitter sends
   function automatic logic [3:0] asc_tx_bits(input asc_pkg::asc_parity_t ps,
         input logic long_chr, input logic two_stop);
      logic [3:0] n;
      n = 4'h1 + (long_chr ? `ASC_LEN_LONG : `ASC_LEN_SHORT);
      n = n + ((ps == asc_pkg::ASC_PAR_NONE) ? 4'h0 : 4'h1);
      n = n + (two_stop ? 4'h2 : 4'h1);
      return n;
   endfunction

   logic [7:0] mode_q;
   logic [7:0] baud_q;
   logic [7:0] status_q;
   logic [7:0] rx_buffer_q;
   logic rx_full_q;
   logic [ADDR_W-1:0] rd_addr_q;
   logic rd_pend_q;
   logic stat_pend_q;
   logic rx_meta_q;
   logic rx_sync_q;
   logic timer_q;
   logic [4:0] pre_q;
   logic txe_s1_q;
   logic txe_en_q;
   logic rxe_s1_q;
   logic rxe_en_q;
   logic [4:0] tx_div_q;
   logic tx_half_q;
   logic tx_busy_q;
   logic [`ASC_FRAME_W-1:0] tx_shift_q;
   logic [3:0] tx_left_q;
   logic [4:0] rx_div_q;
   logic rx_half_q;
   asc_pkg::asc_rx_state_t rx_state_q;
   logic [8:0] rx_shift_q;
   logic [3:0] rx_idx_q;
   logic [2:0] stat_set;
   logic power;
   logic rx_line;
   logic base_tick;
   logic tx_cnt_tick;
   logic rx_cnt_tick;
   logic tx_bit_tick;
   logic [4:0] divisor;
   logic [3:0] rx_len;
   logic [3:0] rx_last;
   logic rx_par_bad;
   logic rx_done;
   logic stat_rd;
   logic buf_rd;
   logic tx_write;
   asc_pkg::asc_parity_t parity;

   assign power = mode_q[`ASC_MODE_POWER];
   assign parity = asc_pkg::asc_parity_t'({mode_q[`ASC_MODE_PS_HI], mode_q[`ASC_MODE_PS_LO]});
   assign divisor = baud_q[4:0];
   assign stat_rd = bus_rd && (bus_addr == `ASC_ADDR_STATUS);
   assign buf_rd = bus_rd && (bus_addr == `ASC_ADDR_DATA);
   assign tx_write = bus_wr && (bus_addr == `ASC_ADDR_DATA);

   // registers written by software
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         mode_q <= `ASC_RST_MODE;
         baud_q <= `ASC_RST_BAUD;
         port1_direction <= `ASC_RST_PORT_DIR;
      end else if (bus_wr) begin
         if (bus_addr == `ASC_ADDR_MODE) begin
            mode_q <= bus_wdata;
         end
         if (bus_addr == `ASC_ADDR_BAUD) begin
            baud_q <= bus_wdata & `ASC_BAUD_MASK;
         end
         if (bus_addr == `ASC_ADDR_PORT_DIR) begin
            port1_direction <= bus_wdata;
         end
      end
   end

   // read path; status answers with the same delay as the other registers, but raises bus_wait for one clock
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         rd_addr_q <= '0;
         rd_pend_q <= 1'b0;
         stat_pend_q <= 1'b0;
         bus_wait <= 1'b0;
         bus_rdata <= 8'h00;
      end else begin
         rd_pend_q <= bus_rd && !stat_rd;
         rd_addr_q <= bus_addr;
         stat_pend_q <= stat_rd;
         bus_wait <= stat_rd;
         if (stat_pend_q) begin
            bus_rdata <= status_q;
         end else if (rd_pend_q) begin
            unique case (rd_addr_q)
               `ASC_ADDR_MODE: bus_rdata <= mode_q;
               `ASC_ADDR_BAUD: bus_rdata <= baud_q;
               `ASC_ADDR_DATA: bus_rdata <= rx_buffer_q;
               `ASC_ADDR_PORT_DIR: bus_rdata <= port1_direction;
               default: bus_rdata <= 8'h00;
            endcase
         end
      end
   end

   // receive pin synchroniser
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         rx_meta_q <= 1'b1;
         rx_sync_q <= 1'b1;
      end else begin
         rx_meta_q <= serial_rx_pin;
         rx_sync_q <= rx_meta_q;
      end
   end

   assign rx_line = power ? rx_sync_q : 1'b1;

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         pre_q <= 5'h00;
         timer_q <= 1'b0;
      end else begin
         pre_q <= power ? pre_q + 5'h01 : 5'h00;
         timer_q <= eight_bit_timer_output;
      end
   end

   always_comb begin
      unique case (asc_pkg::asc_base_sel_t'({baud_q[`ASC_BAUD_TPS_HI], baud_q[`ASC_BAUD_TPS_LO]}))
         asc_pkg::ASC_BASE_TIMER: base_tick = eight_bit_timer_output && !timer_q;
         asc_pkg::ASC_BASE_DIV2: base_tick = (pre_q & `ASC_PRE_DIV2) == `ASC_PRE_DIV2;
         asc_pkg::ASC_BASE_DIV8: base_tick = (pre_q & `ASC_PRE_DIV8) == `ASC_PRE_DIV8;
         asc_pkg::ASC_BASE_DIV32: base_tick = pre_q == `ASC_PRE_DIV32;
      endcase
      base_tick = base_tick && power;
   end

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         txe_s1_q <= 1'b0;
         txe_en_q <= 1'b0;
         rxe_s1_q <= 1'b0;
         rxe_en_q <= 1'b0;
      end else if (!power) begin
         txe_s1_q <= 1'b0;
         txe_en_q <= 1'b0;
         rxe_s1_q <= 1'b0;
         rxe_en_q <= 1'b0;
      end else if (base_tick) begin
         txe_s1_q <= mode_q[`ASC_MODE_TXE];
         txe_en_q <= txe_s1_q;
         rxe_s1_q <= mode_q[`ASC_MODE_RXE];
         rxe_en_q <= rxe_s1_q;
      end
   end

   // counter wraps after k base clocks
   assign tx_cnt_tick = base_tick && (tx_div_q == divisor - 5'h01);
   assign rx_cnt_tick = base_tick && (rx_div_q == divisor - 5'h01);
   // one bit spans two counter outputs
   assign tx_bit_tick = tx_cnt_tick && tx_half_q;

   // transmitter
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         tx_div_q <= 5'h00;
         tx_half_q <= 1'b0;
         tx_busy_q <= 1'b0;
         tx_shift_q <= '1;
         tx_left_q <= 4'h0;
         serial_tx_pin <= 1'b1;
         tx_complete <= 1'b0;
      end else if (!power || !txe_en_q) begin
         tx_div_q <= 5'h00;
         tx_half_q <= 1'b0;
         tx_busy_q <= 1'b0;
         tx_shift_q <= '1;
         tx_left_q <= 4'h0;
         serial_tx_pin <= 1'b1;
         tx_complete <= 1'b0;
      end else if (tx_write) begin
         tx_shift_q <= asc_frame(bus_wdata, parity, mode_q[`ASC_MODE_CL]);
         tx_left_q <= asc_tx_bits(parity, mode_q[`ASC_MODE_CL], mode_q[`ASC_MODE_SL]);
         serial_tx_pin <= 1'b0;
         tx_busy_q <= 1'b1;
         tx_div_q <= 5'h00;
         tx_half_q <= 1'b0;
         tx_complete <= 1'b0;
      end else begin
         tx_complete <= 1'b0;
         if (base_tick) begin
            tx_div_q <= tx_cnt_tick ? 5'h00 : tx_div_q + 5'h01;
         end
         if (tx_cnt_tick) begin
            tx_half_q <= !tx_half_q;
         end
         if (tx_busy_q && tx_bit_tick) begin
            tx_shift_q <= {1'b1, tx_shift_q[`ASC_FRAME_W-1:1]};
            serial_tx_pin <= tx_shift_q[1];
            tx_left_q <= tx_left_q - 4'h1;
            if (tx_left_q == 4'h1) begin
               tx_busy_q <= 1'b0;
               serial_tx_pin <= 1'b1;
               tx_complete <= 1'b1;
            end
         end
      end
   end

   assign rx_len = mode_q[`ASC_MODE_CL] ? `ASC_LEN_LONG : `ASC_LEN_SHORT;
   assign rx_last = (parity == asc_pkg::ASC_PAR_NONE) ? rx_len - 4'h1 : rx_len;

   // only odd and even are judged
   always_comb begin
      rx_par_bad = 1'b0;
      if (parity == asc_pkg::ASC_PAR_ODD) begin
         rx_par_bad = !(^rx_shift_q[8:0]);
      end else if (parity == asc_pkg::ASC_PAR_EVEN) begin
         rx_par_bad = ^rx_shift_q[8:0];
      end
   end

   assign rx_done = (rx_state_q == asc_pkg::ASC_RX_STOP) && rx_cnt_tick
      && rx_half_q;

   assign stat_set = rx_done ?
      {rx_par_bad, !rx_line, rx_full_q} : 3'b000;

   // receiver
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         rx_state_q <= asc_pkg::ASC_RX_IDLE;
         rx_div_q <= 5'h00;
         rx_half_q <= 1'b0;
         rx_shift_q <= 9'h000;
         rx_idx_q <= 4'h0;
      end else if (!power || !rxe_en_q) begin
         rx_state_q <= asc_pkg::ASC_RX_IDLE;
         rx_div_q <= 5'h00;
         rx_half_q <= 1'b0;
         rx_shift_q <= 9'h000;
         rx_idx_q <= 4'h0;
      end else begin
         if (base_tick) begin
            rx_div_q <= rx_cnt_tick ? 5'h00 : rx_div_q + 5'h01;
         end
         if (rx_cnt_tick) begin
            rx_half_q <= !rx_half_q;
         end
         unique case (rx_state_q)
            asc_pkg::ASC_RX_IDLE: begin
               // a low line counts as a start
               if (!rx_line) begin
                  rx_state_q <= asc_pkg::ASC_RX_START;
                  rx_div_q <= 5'h00;
                  rx_half_q <= 1'b0;
                  rx_shift_q <= 9'h000;
                  rx_idx_q <= 4'h0;
               end
            end
            asc_pkg::ASC_RX_START: begin
               // mid start bit: a glitch returns to idle
               if (rx_cnt_tick) begin
                  rx_half_q <= 1'b0;
                  rx_state_q <= rx_line ? asc_pkg::ASC_RX_IDLE : asc_pkg::ASC_RX_DATA;
               end
            end
            asc_pkg::ASC_RX_DATA: begin
               if (rx_cnt_tick && rx_half_q) begin
                  rx_shift_q[rx_idx_q] <= rx_line;
                  rx_idx_q <= rx_idx_q + 4'h1;
                  if (rx_idx_q == rx_last) begin
                     rx_state_q <= asc_pkg::ASC_RX_STOP;
                  end
               end
            end
            asc_pkg::ASC_RX_STOP: begin
               // one stop checked, then hunt again
               if (rx_done) begin
                  rx_state_q <= asc_pkg::ASC_RX_IDLE;
               end
            end
         endcase
      end
   end

   // receive buffer and its unread mark
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         rx_buffer_q <= `ASC_RST_BUFFER;
         rx_full_q <= 1'b0;
         rx_complete <= 1'b0;
         rx_error <= 1'b0;
      end else if (!power) begin
         // buffer back to its reset value
         rx_buffer_q <= `ASC_RST_BUFFER;
         rx_full_q <= 1'b0;
         rx_complete <= 1'b0;
         rx_error <= 1'b0;
      end else begin
         rx_complete <= rx_done;
         rx_error <= |stat_set;
         if (rx_done && !rx_full_q) begin
            // eighth bit reads zero for short characters
            rx_buffer_q <= mode_q[`ASC_MODE_CL] ? rx_shift_q[7:0] : {1'b0, rx_shift_q[6:0]};
            rx_full_q <= 1'b1;
         end else if (buf_rd) begin
            rx_full_q <= 1'b0;
         end
      end
   end

   // error status; a new error wins over a clearing read
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         status_q <= `ASC_RST_STATUS;
      end else if (!power || !mode_q[`ASC_MODE_RXE]) begin
         // cleared while powered down or receive off
         status_q <= `ASC_RST_STATUS;
      end else begin
         status_q <= ((stat_pend_q ? 8'h00 : status_q) | {5'b00000, stat_set}) & `ASC_STAT_MASK;
      end
   end

endmodule // asc_serial_port

// file: testbench/asc_serial_port_asserts.sv
// Purpose: port-level checks of the serial port
// Assumes: bound to every asc_serial_port instance
// Notes: single clock domain, so one default clocking and disable
`timescale 1ns/1ns
`include "asc_params.svh"

module asc_serial_port_asserts #(
   parameter int ADDR_W = 16
) (
   input wire logic clk,
   input wire logic reset_n,
   input wire logic [ADDR_W-1:0] bus_addr,
   input wire logic bus_wr,
   input wire logic bus_rd,
   input wire logic [7:0] bus_wdata,
   input wire logic [7:0] bus_rdata,
   input wire logic bus_wait,
   input wire logic serial_tx_pin,
   input wire logic tx_complete,
   input wire logic rx_complete,
   input wire logic rx_error
);
   logic stat_rd;
   assign stat_rd = bus_rd && (bus_addr == `ASC_ADDR_STATUS);

   default clocking @(posedge clk);
   endclocking
   default disable iff (!reset_n);

   wait_on_status_a: assert property (stat_rd |=> bus_wait)
      else $error("no wait cycle after status read");
   wait_only_status_a: assert property (bus_wait |-> $past(stat_rd))
      else $error("wait cycle without status read");
   wait_single_a: assert property (bus_wait |=> !bus_wait)
      else $error("wait cycle longer than one clock");
   status_upper_zero_a: assert property (stat_rd |=> ##1 bus_rdata[7:3] == 5'h00)
      else $error("status upper bits not zero");
   error_with_done_a: assert property (rx_error |-> rx_complete)
      else $error("receive error without completion");
   rx_done_pulse_a: assert property (rx_complete |=> !rx_complete)
      else $error("receive completion longer than one clock");
   tx_idle_end_a: assert property (tx_complete |-> serial_tx_pin && $past(serial_tx_pin))
      else $error("line not high at end of frame");
   tx_done_pulse_a: assert property (tx_complete |=> !tx_complete)
      else $error("transmit completion longer than one clock");
   baud_bit_zero_a: assert property (bus_rd && bus_addr == `ASC_ADDR_BAUD |=> ##1 !bus_rdata[5])
      else $error("baud bit five reads one");
   power_off_idle_a: assert property ((bus_wr && bus_addr == `ASC_ADDR_MODE
      && !bus_wdata[`ASC_MODE_POWER]) |-> ##[2:4] serial_tx_pin)
      else $error("transmit line not idle after power off");
endmodule // asc_serial_port_asserts

bind asc_serial_port asc_serial_port_asserts #(.ADDR_W(ADDR_W)) asc_serial_port_asserts_inst (
   .clk(clk), .reset_n(reset_n), .bus_addr(bus_addr), .bus_wr(bus_wr), .bus_rd(bus_rd),
   .bus_wdata(bus_wdata), .bus_rdata(bus_rdata), .bus_wait(bus_wait),
   .serial_tx_pin(serial_tx_pin), .tx_complete(tx_complete), .rx_complete(rx_complete),
   .rx_error(rx_error)
);

// file: testbench/asc_peer.sv
// Purpose: remote serial peer on the two line pins
// Assumes: bit time in clocks set by the bench before each frame
// Notes: monitor keeps the ten bits that follow each start bit
`timescale 1ns/1ns

module asc_peer (
   input wire logic clk,
   input wire logic serial_tx_pin,
   output logic serial_rx_pin
);
   int bit_clks = 32;
   logic [9:0] cap_bits = 10'h000;

   initial serial_rx_pin = 1'b1;

   task automatic send(input logic [7:0] d, input int nb, input logic use_par,
      input logic par, input logic stop);
      @(posedge clk);
      serial_rx_pin <= 1'b0;
      repeat (bit_clks) @(posedge clk);
      for (int i = 0; i < nb; i++) begin
         serial_rx_pin <= d[i];
         repeat (bit_clks) @(posedge clk);
      end
      if (use_par) begin
         serial_rx_pin <= par;
         repeat (bit_clks) @(posedge clk);
      end
      serial_rx_pin <= stop;
      // a bad stop is cut short so the low level cannot look like a new start
      repeat (stop ? bit_clks : bit_clks / 2 + 4) @(posedge clk);
      serial_rx_pin <= 1'b1;
      repeat (bit_clks) @(posedge clk);
   endtask

   always begin
      @(negedge serial_tx_pin);
      repeat (bit_clks / 2) @(posedge clk);
      for (int i = 0; i < 10; i++) begin
         repeat (bit_clks) @(posedge clk);
         cap_bits[i] = serial_tx_pin;
      end
   end
endmodule // asc_peer

// file: testbench/tb_asc_serial_port.sv
// Purpose: self-checking bench for the serial port
// Assumes: peer model drives the receive line
// Notes: baud 48 gives base clk/2 and k=8, 32 clocks a bit
`timescale 1ns/1ns
`include "asc_params.svh"

module tb_asc_serial_port;
   logic clk = 1'b0;
   logic reset_n = 1'b0;
   logic [15:0] bus_addr = 16'h0000;
   logic bus_wr = 1'b0;
   logic bus_rd = 1'b0;
   logic [7:0] bus_wdata = 8'h00;
   logic timer_out = 1'b0;
   logic [7:0] bus_rdata;
   logic [7:0] port1_direction;
   logic bus_wait, serial_tx_pin, serial_rx_pin, tx_complete, rx_complete, rx_error;
   int n_fail = 0;
   int n_compared = 0;

   always #20 clk = ~clk;
   always @(posedge clk) timer_out <= ~timer_out;

   asc_serial_port asc_serial_port_inst (.clk(clk), .reset_n(reset_n), .bus_addr(bus_addr),
      .bus_wr(bus_wr), .bus_rd(bus_rd), .bus_wdata(bus_wdata), .bus_rdata(bus_rdata),
      .bus_wait(bus_wait), .eight_bit_timer_output(timer_out), .serial_rx_pin(serial_rx_pin),
      .serial_tx_pin(serial_tx_pin), .port1_direction(port1_direction),
      .tx_complete(tx_complete), .rx_complete(rx_complete), .rx_error(rx_error));
   asc_peer asc_peer_inst (.clk(clk), .serial_tx_pin(serial_tx_pin),
      .serial_rx_pin(serial_rx_pin));

   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      n_compared++;
      if (got !== exp) begin
         n_fail++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic chk_rng(input int got, input int lo, input int hi);
      n_compared++;
      if (got < lo || got > hi) begin
         n_fail++;
         $display("Error at %0t: count %0d outside %0d..%0d", $time, got, lo, hi);
      end
   endtask

   task automatic wr(input logic [15:0] a, input logic [7:0] d);
      @(posedge clk);
      bus_addr <= a;
      bus_wdata <= d;
      bus_wr <= 1'b1;
      @(posedge clk);
      bus_wr <= 1'b0;
   endtask

   task automatic rdc(input logic [15:0] a, input logic [7:0] exp);
      @(posedge clk);
      bus_addr <= a;
      bus_rd <= 1'b1;
      @(posedge clk);
      bus_rd <= 1'b0;
      @(negedge clk);
      chk({7'h00, bus_wait}, {7'h00, a == `ASC_ADDR_STATUS});
      @(negedge clk);
      chk(bus_rdata, exp);
   endtask

   // power before enables, base set while off
   task automatic setup(input logic [7:0] baud, input logic [7:0] fmt);
      wr(`ASC_ADDR_MODE, 8'h01);
      // two slowest base ticks before re-enabling
      repeat (64) @(posedge clk);
      wr(`ASC_ADDR_BAUD, baud);
      // format with enables off, bit zero set
      wr(`ASC_ADDR_MODE, fmt | 8'h81);
      wr(`ASC_ADDR_MODE, fmt | 8'hE1);
      // enable sync plus half a base clock, slowest base
      repeat (80) @(posedge clk);
   endtask

   task automatic t_regs;
      rdc(`ASC_ADDR_MODE, 8'h01);
      rdc(`ASC_ADDR_BAUD, 8'h1F);
      rdc(`ASC_ADDR_STATUS, 8'h00);
      rdc(`ASC_ADDR_DATA, 8'hFF);
      rdc(`ASC_ADDR_PORT_DIR, 8'hFF);
      rdc(16'h1234, 8'h00);
      wr(`ASC_ADDR_PORT_DIR, 8'hFE);
      rdc(`ASC_ADDR_PORT_DIR, 8'hFE);
      wr(`ASC_ADDR_BAUD, 8'hFF);
      rdc(`ASC_ADDR_BAUD, 8'hDF);
      wr(`ASC_ADDR_STATUS, 8'h07);
      rdc(`ASC_ADDR_STATUS, 8'h00);
      $display("register test done");
   endtask

   task automatic t_tx(input logic [7:0] baud, input logic [7:0] fmt, input logic [7:0] d,
      input logic [9:0] exp, input int nbits, input int bclk);
      int cnt;
      cnt = 0;
      setup(baud, fmt);
      asc_peer_inst.bit_clks = bclk;
      wr(`ASC_ADDR_DATA, d);
      while (tx_complete !== 1'b1 && cnt < 8000) begin
         @(negedge clk);
         cnt++;
      end
      repeat (2 * bclk) @(posedge clk);
      // the start bit may lose up to one base clock waiting for the first tick
      chk_rng(cnt, nbits * bclk - bclk / 16 - 2, nbits * bclk + 4);
      chk(asc_peer_inst.cap_bits[7:0], exp[7:0]);
      chk({6'h00, asc_peer_inst.cap_bits[9:8]}, {6'h00, exp[9:8]});
      $display("transmit test done");
   endtask

   task automatic t_rx(input logic [7:0] fmt, input logic [7:0] d, input int nb,
      input logic up, input logic par, input logic stop, input logic [7:0] exp_buf,
      input logic [7:0] exp_st);
      logic err;
      int n;
      err = 1'bx;
      n = 0;
      setup(8'h48, fmt);
      asc_peer_inst.bit_clks = 32;
      fork
         asc_peer_inst.send(d, nb, up, par, stop);
         begin
            while (rx_complete !== 1'b1 && n < 2000) begin
               @(negedge clk);
               n++;
            end
            err = rx_error;
         end
      join
      chk({7'h00, err}, {7'h00, exp_st != 8'h00});
      rdc(`ASC_ADDR_STATUS, exp_st);
      rdc(`ASC_ADDR_DATA, exp_buf);
      rdc(`ASC_ADDR_STATUS, 8'h00);
      $display("receive test done");
   endtask

   task automatic t_ovr;
      setup(8'h48, 8'h04);
      asc_peer_inst.bit_clks = 32;
      asc_peer_inst.send(8'h11, 8, 1'b0, 1'b0, 1'b1);
      asc_peer_inst.send(8'h22, 8, 1'b0, 1'b0, 1'b1);
      rdc(`ASC_ADDR_STATUS, 8'h01);
      rdc(`ASC_ADDR_DATA, 8'h11);
      asc_peer_inst.send(8'h33, 8, 1'b0, 1'b0, 1'b1);
      asc_peer_inst.send(8'h44, 8, 1'b0, 1'b0, 1'b1);
      // enables off first, then power off
      wr(`ASC_ADDR_MODE, 8'h85);
      wr(`ASC_ADDR_MODE, 8'h05);
      rdc(`ASC_ADDR_STATUS, 8'h00);
      rdc(`ASC_ADDR_DATA, 8'hFF);
      $display("overrun and power-off test done");
   endtask

   task automatic tally_and_finish;
      $display("compared %0d, failed %0d", n_compared, n_fail);
      if (n_fail == 0 && n_compared > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask

   initial begin
      repeat (40000) @(posedge clk);
      n_fail++;
      $display("Error at %0t: run did not finish", $time);
      tally_and_finish();
   end

   initial begin
      repeat (12) @(posedge clk);
      reset_n <= 1'b1;
      t_regs();
      t_tx(8'h48, 8'h1C, 8'h55, 10'h255, 11, 32);
      t_tx(8'h88, 8'h12, 8'h36, 10'h3B6, 11, 128);
      t_tx(8'hC8, 8'h0C, 8'hFF, 10'h2FF, 11, 512);
      t_tx(8'h09, 8'h00, 8'h01, 10'h381, 9, 36);
      t_rx(8'h14, 8'hA5, 8, 1'b1, 1'b1, 1'b1, 8'hA5, 8'h00);
      t_rx(8'h14, 8'hA5, 8, 1'b1, 1'b0, 1'b1, 8'hA5, 8'h04);
      t_rx(8'h1C, 8'hA5, 8, 1'b1, 1'b1, 1'b1, 8'hA5, 8'h04);
      t_rx(8'h0C, 8'h3C, 8, 1'b1, 1'b1, 1'b1, 8'h3C, 8'h00);
      t_rx(8'h00, 8'hC3, 7, 1'b0, 1'b0, 1'b1, 8'h43, 8'h00);
      t_rx(8'h06, 8'h5A, 8, 1'b0, 1'b0, 1'b0, 8'h5A, 8'h02);
      t_ovr();
      tally_and_finish();
   end
endmodule // tb_asc_serial_port
